// >>> verilog/pkf_top.v
// packet fifo with rewrite and resend, staging input buffer, apb registers
// assumes: one clock i_clk, synchronous active-low reset, apb master
`include "pkf_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module pkf_top #(
    parameter DATA_WIDTH = 18,
    parameter PORT_W     = 36,
    parameter DO_REG     = 1,
    parameter SAME_CLOCK = 0,
    parameter USE_EMPTY  = 1,
    parameter USE_FULL   = 1,
    parameter STG_DEPTH  = 16,
    parameter STG_AW     = 4
) (
    // clock, reset and clock enables
    input  wire              i_clk,
    input  wire              i_nrst,
    input  wire              i_ce,
    input  wire              i_wce,
    input  wire              i_rce,
    input  wire              i_orce,
    // write port
    input  wire              i_wr_valid,
    output wire              o_wr_ready,
    input  wire [PORT_W-1:0] i_write_data_in,
    input  wire              i_wr_eop,
    input  wire              i_wr_err,
    // read port
    input  wire              i_rd_en,
    input  wire              i_rd_nak,
    output wire [PORT_W-1:0] o_rd_data,
    output wire              o_rd_eop,
    // flags
    output reg               o_empty,
    output reg               o_full,
    output reg               o_almost_empty,
    output reg               o_almost_full,
    // apb slave
    input  wire              i_psel,
    input  wire              i_penable,
    input  wire              i_pwrite,
    input  wire [11:0]       i_paddr,
    input  wire [31:0]       i_pwdata,
    output reg  [31:0]       o_prdata,
    output reg               o_pready,
    output reg               o_pslverr
);

    // ==========================================================
    // geometry
    function integer pkf_depth;
        input integer w;
        begin
            pkf_depth = (w % 9 == 0) ? 18432 / w : 16384 / w;
        end
    endfunction

    function integer pkf_log2;
        input integer v;
        integer k;
        begin
            pkf_log2 = 0;
            for (k = v - 1; k > 0; k = k >> 1) begin
                pkf_log2 = pkf_log2 + 1;
            end
        end
    endfunction

    localparam DEPTH = pkf_depth(DATA_WIDTH);  // [R3]
    localparam AW    = pkf_log2(DEPTH);
    localparam PW    = AW + 1;
    localparam SW    = DATA_WIDTH + 2;
    localparam integer  AE_RST_I = `PKF_AE_RST;
    localparam integer  AF_RST_I = `PKF_AF_RST;
    localparam [PW-1:0] AE_RST   = AE_RST_I[PW-1:0];
    localparam [PW-1:0] AF_RST   = AF_RST_I[PW-1:0];

    // pointer code conversions
    function [PW-1:0] to_gray;
        input [PW-1:0] b;
        begin
            to_gray = b ^ (b >> 1);
        end
    endfunction

    function [PW-1:0] from_gray;
        input [PW-1:0] g;
        integer j;
        begin
            from_gray         = g;
            for (j = PW - 2; j >= 0; j = j - 1) begin
                from_gray[j] = from_gray[j+1] ^ g[j];
            end
        end
    endfunction

    // ==========================================================
    // declarations
    reg  [DATA_WIDTH:0] mem_q [0:DEPTH-1];
    reg  [PW-1:0]       wptr_q;
    reg  [PW-1:0]       wptr_d;
    reg  [PW-1:0]       wstart_q;
    reg  [PW-1:0]       wstart_d;
    reg  [PW-1:0]       rptr_q;
    reg  [PW-1:0]       rptr_d;
    reg  [PW-1:0]       rel_q;
    reg  [PW-1:0]       rel_d;
    reg  [PW-1:0]       ws1_q;
    reg  [PW-1:0]       ws2_q;
    reg  [PW-1:0]       rs1_q;
    reg  [PW-1:0]       rs2_q;
    reg                 empty_q;
    reg                 full_q;
    reg                 pkt_en_q;
    reg  [PW-1:0]       ae_thr_q;
    reg  [PW-1:0]       af_thr_q;
    reg  [PORT_W:0]     rword_q;
    reg  [PORT_W:0]     oword_q;
    reg  [PORT_W:0]     rword_d;
    reg  [31:0]         rdata_d;
    reg                 slverr_d;
    wire [PW-1:0]       wseen;
    wire [PW-1:0]       rseen;
    wire [PW-1:0]       rcnt;
    wire [PW-1:0]       wcnt;
    wire                empty_d;
    wire                full_d;
    wire                stg_valid;
    wire [SW-1:0]       stg_data;
    wire                wr_go;
    wire                rd_go;
    wire                nak_go;
    wire                w_eop;
    wire                w_err;

    // ==========================================================
    // staging buffer in front of the store; stalls while the store is full
    pkf_stage_fifo #(
        .W     (SW),
        .DEPTH (STG_DEPTH),
        .AW    (STG_AW)
    ) u_stage (
        .i_clk       (i_clk),
        .i_nrst      (i_nrst),
        .i_ce        (i_ce),
        .i_in_valid  (i_wr_valid),
        .o_in_ready  (o_wr_ready),
        .i_in_data   ({i_wr_err, i_wr_eop,
                       i_write_data_in[DATA_WIDTH-1:0]}), // [R10]
        .o_out_valid (stg_valid),
        .i_out_ready (~full_q & i_wce),
        .o_out_data  (stg_data)
    );

    // ==========================================================
    // port strobes
    assign w_eop  = stg_data[DATA_WIDTH];
    assign w_err  = stg_data[DATA_WIDTH+1];
    assign wr_go  = i_ce & i_wce & stg_valid & ~full_q;   // [R17] [R13]
    assign rd_go  = i_ce & i_rce & i_rd_en & ~empty_q;    // [R17] [R13]
    assign nak_go = i_ce & i_rce & i_rd_nak & pkt_en_q;

    // write-side next pointers: rewind on a failed packet end
    always @* begin
        wptr_d   = wptr_q;
        wstart_d = wstart_q;
        if (wr_go) begin
            if (pkt_en_q & w_eop & w_err) begin
                wptr_d = wstart_q;                        // [R14]
            end else begin
                wptr_d = wptr_q + 1'b1;
            end
            if (pkt_en_q & w_eop & ~w_err) begin
                wstart_d = wptr_q + 1'b1;
            end
        end
        if (!pkt_en_q) begin
            wstart_d = wptr_d;
        end
    end

    // read-side next pointers: resend wins over a read
    always @* begin
        rptr_d = rptr_q;
        rel_d  = rel_q;
        if (nak_go) begin
            rptr_d = rel_q;                               // [R15]
        end else if (rd_go) begin
            rptr_d = rptr_q + 1'b1;
            if (pkt_en_q & mem_q[rptr_q[AW-1:0]][DATA_WIDTH] & ~i_rd_nak) begin
                rel_d = rptr_q + 1'b1;                    // [R1]
            end
        end
        if (!pkt_en_q) begin
            rel_d = rptr_d;
        end
    end

    // ==========================================================
    // pointer views seen across the port boundary
    generate
        if (SAME_CLOCK != 0) begin : g_same
            assign wseen = wstart_q;
            assign rseen = rel_q;
        end else begin : g_dual
            assign wseen = from_gray(ws2_q);              // [R5] [R18]
            assign rseen = from_gray(rs2_q);              // [R5] [R18]
        end
    endgenerate

    // flag terms; full uses the consumed-packet pointer in packet mode
    assign rcnt    = wseen - rptr_d;
    assign wcnt    = wptr_d - rseen;
    assign empty_d = (rptr_d == wseen);
    assign full_d  = (wptr_d == {~rseen[PW-1], rseen[PW-2:0]}); // [R2]

    // ==========================================================
    // write side state
    always @(posedge i_clk) begin
        if (!i_nrst) begin
            wptr_q   <= {PW{1'b0}};                       // [R19]
            wstart_q <= {PW{1'b0}};
            rs1_q    <= {PW{1'b0}};
            rs2_q    <= {PW{1'b0}};
            full_q   <= 1'b0;
        end else if (i_ce & i_wce) begin
            if (wr_go) begin
                mem_q[wptr_q[AW-1:0]] <= stg_data[DATA_WIDTH:0];
            end
            wptr_q   <= wptr_d;
            wstart_q <= wstart_d;
            rs1_q    <= to_gray(rel_q);                   // [R18]
            rs2_q    <= rs1_q;
            full_q   <= full_d;
        end
    end

    // read side state
    always @(posedge i_clk) begin
        if (!i_nrst) begin
            rptr_q  <= {PW{1'b0}};                        // [R19]
            rel_q   <= {PW{1'b0}};
            ws1_q   <= {PW{1'b0}};
            ws2_q   <= {PW{1'b0}};
            empty_q <= 1'b1;
        end else if (i_ce & i_rce) begin
            rptr_q  <= rptr_d;
            rel_q   <= rel_d;
            ws1_q   <= to_gray(wstart_d);                 // [R16]
            ws2_q   <= ws1_q;
            empty_q <= empty_d;                           // [R16]
        end
    end

    // ==========================================================
    // read data word, zero above the configured width
    always @* begin
        rword_d                 = {(PORT_W+1){1'b0}};
        rword_d[DATA_WIDTH-1:0] = mem_q[rptr_q[AW-1:0]][DATA_WIDTH-1:0];
        rword_d[PORT_W]         = mem_q[rptr_q[AW-1:0]][DATA_WIDTH];
    end

    // first read register and optional output register
    always @(posedge i_clk) begin
        if (!i_nrst) begin
            rword_q <= {(PORT_W+1){1'b0}};
            oword_q <= {(PORT_W+1){1'b0}};
        end else if (i_ce) begin
            if (rd_go) begin
                rword_q <= rword_d;                       // [R11]
            end
            if (i_orce) begin
                oword_q <= rword_q;                       // [R4] [R13]
            end
        end
    end

    generate
        if (DO_REG == 1) begin : g_oreg
            assign o_rd_data = oword_q[PORT_W-1:0];       // [R4]
            assign o_rd_eop  = oword_q[PORT_W];
        end else begin : g_noreg
            assign o_rd_data = rword_q[PORT_W-1:0];
            assign o_rd_eop  = rword_q[PORT_W];
        end
    endgenerate

    // ==========================================================
    // flag outputs, empty and full gated by their use parameters
    always @(posedge i_clk) begin
        if (!i_nrst) begin
            o_empty        <= (USE_EMPTY == 1);           // [R19]
            o_full         <= 1'b0;
            o_almost_empty <= 1'b1;
            o_almost_full  <= 1'b0;
        end else if (i_ce) begin
            if (i_rce) begin
                o_empty        <= (USE_EMPTY == 1) & empty_d; // [R6]
                o_almost_empty <= (rcnt <= ae_thr_q);     // [R8]
            end
            if (i_wce) begin
                o_full        <= (USE_FULL == 1) & full_d; // [R7]
                o_almost_full <= (wcnt >= af_thr_q);      // [R9]
            end
        end
    end

    // ==========================================================
    // apb read mux and address check
    always @* begin
        rdata_d  = 32'h0000_0000;
        slverr_d = 1'b0;
        case (i_paddr)
            `PKF_CTRL_OFS: rdata_d[`PKF_CTRL_PKT] = pkt_en_q;
            `PKF_AE_OFS:   rdata_d[PW-1:0] = ae_thr_q;
            `PKF_AF_OFS:   rdata_d[PW-1:0] = af_thr_q;
            `PKF_STAT_OFS: begin
                rdata_d[`PKF_STAT_EMP]              = empty_q;
                rdata_d[`PKF_STAT_FUL]              = full_q;
                rdata_d[`PKF_STAT_AEMP]             = o_almost_empty;
                rdata_d[`PKF_STAT_AFUL]             = o_almost_full;
                rdata_d[`PKF_STAT_CNT+PW-1:`PKF_STAT_CNT] = wcnt;
            end
            default:       slverr_d = 1'b1;
        endcase
    end

    // apb slave: no wait state, answer in the first access cycle
    always @(posedge i_clk) begin
        if (!i_nrst) begin
            o_prdata  <= 32'h0000_0000;
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
            pkt_en_q  <= `PKF_CTRL_RST;
            ae_thr_q  <= AE_RST;
            af_thr_q  <= AF_RST;
        end else if (i_ce) begin
            o_pready  <= i_psel & ~i_penable;
            o_pslverr <= i_psel & ~i_penable & slverr_d;
            if (i_psel & ~i_penable) begin
                o_prdata <= i_pwrite ? 32'h0000_0000 : rdata_d;
            end
            if (i_psel & i_penable & o_pready & i_pwrite) begin
                case (i_paddr)
                    `PKF_CTRL_OFS: pkt_en_q <= i_pwdata[`PKF_CTRL_PKT];
                    `PKF_AE_OFS:   ae_thr_q <= i_pwdata[PW-1:0];
                    `PKF_AF_OFS:   af_thr_q <= i_pwdata[PW-1:0];
                    default:       pkt_en_q <= pkt_en_q;
                endcase
            end
        end
    end

endmodule // pkf_top

`default_nettype wire

// >>> pkg/pkf_regs.vh
// register map, field positions and reset values of the packet fifo
// assumes: included by the packet fifo design files, 32-bit apb words
//
// How it works
// [R1] a packet is consumed when its end word is read with resend low
// [R2] in packet mode full compares against the last consumed packet end
// [R3] width parameter 18 gives 1024 words of 18 bits on both ports
// [R4] output register parameter 1 adds one more register on read data
// [R5] same-clock parameter 0 selects the decoupled dual-clock pointer path
// [R6] the empty output is driven only when its use parameter is 1
// [R7] the full output is driven only when its use parameter is 1
// [R8] near-empty rises when the word count is at or below the low mark
// [R9] near-full rises when the word count is at or above the high mark
// [R10] the writer uses the low data bits and holds the upper bits low
// [R11] read data sits in the low bits, upper output bits read zero
// [R12] the integrator keeps default values for parameters it does not use
// [R13] separate write, read and output-register clock enables gate each port
// [R14] end word with error moves the write pointer back to packet start
// [R15] a resend request moves the read pointer back to packet start
// [R16] empty falls one read cycle after a write, two in dual-clock mode
// [R17] write pointer holds while full, read pointer holds while empty
// [R18] dual-clock pointers cross in gray code through two flip-flops
// [R19] reset clears pointers, sets empty flags and clears full flags
`ifndef PKF_REGS_VH
`define PKF_REGS_VH

// ==========================================================
// register offsets (byte addresses)
`define PKF_CTRL_OFS   12'h000
`define PKF_AE_OFS     12'h004
`define PKF_AF_OFS     12'h008
`define PKF_STAT_OFS   12'h00c

// ==========================================================
// field positions
`define PKF_CTRL_PKT   0
`define PKF_STAT_EMP   0
`define PKF_STAT_FUL   1
`define PKF_STAT_AEMP  2
`define PKF_STAT_AFUL  3
`define PKF_STAT_CNT   16

// ==========================================================
// reset values
`define PKF_CTRL_RST   1'b0
`define PKF_AE_RST     4
`define PKF_AF_RST     1020

`endif

// >>> verilog/pkf_stage_fifo.v
// staging fifo of flip-flops with valid and ready on both sides
// assumes: one clock, synchronous active-low reset, global clock enable
`timescale 1ns/1ps
`default_nettype none

module pkf_stage_fifo #(
    parameter W     = 20,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    // clock and reset
    input  wire         i_clk,
    input  wire         i_nrst,
    input  wire         i_ce,
    // filling side
    input  wire         i_in_valid,
    output reg          o_in_ready,
    input  wire [W-1:0] i_in_data,
    // draining side
    output reg          o_out_valid,
    input  wire         i_out_ready,
    output wire [W-1:0] o_out_data
);

    reg  [W-1:0] mem_q [0:DEPTH-1];
    reg  [AW-1:0] wr_q;
    reg  [AW-1:0] rd_q;
    reg  [AW:0]   cnt_q;
    reg  [AW:0]   cnt_d;
    wire          push;
    wire          pop;

    // ==========================================================
    // handshake terms
    assign push       = i_in_valid & o_in_ready;
    assign pop        = o_out_valid & i_out_ready;
    assign o_out_data = mem_q[rd_q];

    // next fill count
    always @* begin
        cnt_d = cnt_q;
        if (push & ~pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop & ~push) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    // pointers, flags and storage
    always @(posedge i_clk) begin
        if (!i_nrst) begin
            wr_q        <= {AW{1'b0}};
            rd_q        <= {AW{1'b0}};
            cnt_q       <= {(AW+1){1'b0}};
            o_in_ready  <= 1'b0;
            o_out_valid <= 1'b0;
        end else if (i_ce) begin
            if (push) begin
                mem_q[wr_q] <= i_in_data;
                wr_q        <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            cnt_q       <= cnt_d;
            o_in_ready  <= (cnt_d != DEPTH[AW:0]);
            o_out_valid <= (cnt_d != {(AW+1){1'b0}});
        end
    end

endmodule // pkf_stage_fifo

`default_nettype wire

// >>> dv/pkf_assertions.sv
// checker for the packet fifo flags, read timing and apb answer
// assumes: bound to pkf_top, one clock, synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none

module pkf_checker #(
    parameter DATA_WIDTH = 18,
    parameter PORT_W     = 36
) (
    // clock and reset
    input wire logic              i_clk,
    input wire logic              i_nrst,
    // stream ports
    input wire logic              i_ce,
    input wire logic              i_rce,
    input wire logic              i_wce,
    input wire logic              i_wr_valid,
    input wire logic              o_wr_ready,
    input wire logic              i_rd_en,
    input wire logic [PORT_W-1:0] o_rd_data,
    // flags and apb
    input wire logic              o_empty,
    input wire logic              o_full,
    input wire logic              o_almost_empty,
    input wire logic              o_almost_full,
    input wire logic              i_psel,
    input wire logic              i_penable,
    input wire logic              o_pready
);
    // ========
    // writes and reads that the fifo takes
    wire wt = i_wr_valid & o_wr_ready & i_ce;
    wire rt = i_rd_en & ~o_empty & i_rce & i_ce;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    // ========
    // flag, data and apb relations
    reset_flags_a: assert property (disable iff (1'b0)
        !i_nrst |=> o_empty && o_almost_empty && !o_full
            && !o_almost_full && !o_wr_ready)
        else $error("flags wrong after reset");
    empty_hold_a: assert property (
        o_empty && !wt && !$past(wt) && !$past(wt, 2) && !$past(wt, 3)
            && $past(i_wce, 3) && $past(i_rce, 3) && $past(i_rce, 2)
            && $past(i_rce) |=> o_empty)
        else $error("empty fell too early");
    read_gate_a: assert property (
        !rt |=> ##1 $stable(o_rd_data))
        else $error("read data moved without a read");
    upper_zero_a: assert property (
        o_rd_data[PORT_W-1:DATA_WIDTH] == '0)
        else $error("upper read bits not zero");
    flag_excl_a: assert property (
        !(o_full && o_empty))
        else $error("full and empty together");
    empty_near_a: assert property (
        o_empty |-> o_almost_empty)
        else $error("empty without near-empty");
    full_near_a: assert property (
        o_full |-> o_almost_full)
        else $error("full without near-full");
    full_hold_a: assert property (
        o_full && !rt && !$past(rt) && !$past(rt, 2) && !$past(rt, 3)
            && $past(i_wce, 3) && $past(i_wce, 2) && $past(i_wce)
            |=> o_full)
        else $error("full fell without a read");
    apb_answer_a: assert property (
        i_psel && !i_penable |=> o_pready ##1 !o_pready)
        else $error("apb answer not one cycle after setup");
endmodule // pkf_checker

bind pkf_top pkf_checker #(.DATA_WIDTH(DATA_WIDTH), .PORT_W(PORT_W)) u_chk (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_ce(i_ce), .i_rce(i_rce),
    .i_wce(i_wce),
    .i_wr_valid(i_wr_valid), .o_wr_ready(o_wr_ready), .i_rd_en(i_rd_en),
    .o_rd_data(o_rd_data), .o_empty(o_empty), .o_full(o_full),
    .o_almost_empty(o_almost_empty), .o_almost_full(o_almost_full),
    .i_psel(i_psel), .i_penable(i_penable), .o_pready(o_pready));

`default_nettype wire

// >>> dv/pkf_peer.sv
// writer and reader logic on the far side of the packet fifo
// assumes: one clock, words pushed and reads requested by the bench
`timescale 1ns/1ps
`default_nettype none

module pkf_peer #(
    parameter DW = 18,
    parameter PW = 36
) (
    // clock
    input  wire logic          i_clk,
    // writer
    input  wire logic          i_wr_ready,
    output logic               o_wr_valid,
    output logic [PW-1:0]      o_data,
    output logic               o_eop,
    output logic               o_err,
    // reader
    input  wire logic          i_empty,
    input  wire logic          i_pace,
    output logic               o_rd_en
);
    logic [DW+1:0] wq[$];
    logic [DW+1:0] w;
    int            req = 0;
    int            got = 0;

    initial begin
        {o_wr_valid, o_data, o_eop, o_err, o_rd_en} = '0;
    end

    task push(input logic [DW+1:0] x);
        wq.push_back(x);
    endtask

    task pull(input int n);
        req = req + n;
    endtask

    // ========
    // writer holds each word until the fifo takes it
    always @(posedge i_clk) begin
        if (!o_wr_valid || i_wr_ready) begin
            if (wq.size() > 0) begin
                w = wq.pop_front();
                o_wr_valid <= 1'b1;
                o_data <= {{(PW-DW){1'b0}}, w[DW-1:0]};
                {o_err, o_eop} <= w[DW+1:DW];
            end else begin
                o_wr_valid <= 1'b0;
                o_data[DW-1:0] <= ~o_data[DW-1:0]; // idle data is junk
            end
        end
    end

    // ========
    // reader counts taken reads, paced by the bench
    always @(posedge i_clk) begin
        if (o_rd_en && !i_empty) got = got + 1;
        o_rd_en <= (req > got) && i_pace;
    end
endmodule // pkf_peer

`default_nettype wire

// >>> dv/pkf_testbench.sv
// self-checking bench of the packet fifo: apb, stream, packets
// assumes: pkf_top with default parameters, checker bound to it
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic        clk = 0, nrst = 0, pace = 1, slow = 0, nak = 0;
    logic        psel = 0, pen = 0, pwr = 0, d1 = 0, d2 = 0;
    logic        ce = 1, wce = 1, rce = 1, orce = 1;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0;
    wire         wv, wr, eop, err, ren, reop, emp, ful, aemp, aful;
    wire         prdy, perr;
    wire  [35:0] wdata, rdata;
    wire  [31:0] prdata;
    int          bad_count = 0, checked = 0, cyc = 0, seed = 32'h3399;
    logic [36:0] exp_q[$];
    logic [32:0] apb_q[$];
    logic [19:0] pk[$];

    always #12.5 clk = ~clk;

    pkf_top dut (
        .i_clk(clk), .i_nrst(nrst), .i_ce(ce), .i_wce(wce),
        .i_rce(rce), .i_orce(orce), .i_wr_valid(wv), .o_wr_ready(wr),
        .i_write_data_in(wdata), .i_wr_eop(eop), .i_wr_err(err),
        .i_rd_en(ren), .i_rd_nak(nak), .o_rd_data(rdata), .o_rd_eop(reop),
        .o_empty(emp), .o_full(ful), .o_almost_empty(aemp),
        .o_almost_full(aful), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(prdy), .o_pslverr(perr));

    pkf_peer peer (
        .i_clk(clk), .i_wr_ready(wr), .o_wr_valid(wv), .o_data(wdata),
        .o_eop(eop), .o_err(err), .i_empty(emp), .i_pace(pace),
        .o_rd_en(ren));

    task check(input logic [36:0] seen, input logic [36:0] want);
        checked++;
        if (seen !== want) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, want);
        end
    endtask

    task give_verdict;
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // apb transfer, expected {pslverr, read data} noted first
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
             input logic [32:0] e);
        apb_q.push_back(e);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk) pen <= 1'b1;
        @(posedge clk);
        while (prdy !== 1'b1) @(posedge clk);
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask

    // k random words, the last one carrying {err, eop}
    task put_words(input int k, input logic [1:0] tail);
        logic [19:0] v;
        pk.delete();
        for (int j = 0; j < k; j++) begin
            v = {(j == k - 1) ? tail : 2'b00, 18'($random(seed))};
            pk.push_back(v);
            peer.push(v);
        end
    endtask

    task want_words(input int lo, input int hi);
        for (int j = lo; j <= hi; j++)
            exp_q.push_back({pk[j][18], 18'h0, pk[j][17:0]});
    endtask

    task drain;
        while (peer.got < peer.req) @(posedge clk);
        repeat (6) @(posedge clk);
    endtask

    // ========
    // monitor: apb answers, read data, pacing, timeout
    always @(posedge clk) begin
        cyc++;
        if (psel && pen && prdy)
            check({perr, pwr ? 32'h0 : prdata}, apb_q.pop_front());
        if (d2) check({reop, rdata}, exp_q.pop_front());
        d2 <= d1;
        d1 <= ren && !emp && !nak;
        pace <= !slow || ($random(seed) % 2 == 0);
        wce <= !slow || ($random(seed) % 2 == 0);
        if (cyc == 40000) begin
            bad_count++;
            give_verdict;
        end
    end

    // ========
    // main sequence
    initial begin
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        check({aful, ful, aemp, emp}, 4'b0011);
        apb(0, 12'h00c, 0, 33'h5);
        apb(0, 12'h000, 0, 33'h0);
        apb(0, 12'h008, 0, 33'd1020);
        apb(1, 12'h004, 32'd5, 33'h0);
        apb(0, 12'h004, 0, 33'd5);
        apb(0, 12'h010, 0, 33'h1_0000_0000);
        apb(1, 12'h01c, 32'hffff, 33'h1_0000_0000);
        $display("test registers done");
        ce <= 1'b0;
        repeat (5) @(posedge clk);
        ce <= 1'b1;
        check({aful, ful, aemp, emp}, 4'b0011);
        slow = 1;
        put_words(6, 2'b00);
        want_words(0, 5);
        repeat (40) @(posedge clk);
        check(aemp, 1'b0);
        peer.pull(1);
        drain;
        check(aemp, 1'b1);
        peer.pull(5);
        drain;
        check(emp, 1'b1);
        $display("test stream done");
        slow = 0;
        put_words(1044, 2'b00);
        want_words(0, 1043);
        while (wr !== 1'b0) @(posedge clk);
        repeat (4) @(posedge clk);
        check({aful, ful, wr}, 3'b110);
        apb(0, 12'h00c, 0, 33'h0400_000a);
        peer.pull(1044);
        drain;
        check(emp, 1'b1);
        $display("test fill done");
        apb(1, 12'h000, 32'h1, 33'h0);
        put_words(3, 2'b11);
        repeat (10) @(posedge clk);
        check(emp, 1'b1);
        put_words(3, 2'b01);
        want_words(0, 2);
        peer.pull(3);
        drain;
        check(emp, 1'b1);
        $display("test rewrite done");
        put_words(4, 2'b01);
        want_words(0, 1);
        peer.pull(2);
        drain;
        nak <= 1'b1;
        @(posedge clk) nak <= 1'b0;
        @(posedge clk);
        want_words(0, 3);
        peer.pull(4);
        drain;
        check(emp, 1'b1);
        $display("test resend done");
        give_verdict;
    end
endmodule // testbench

`default_nettype wire
